// [pkg/osc_ctrl_pkg.sv]
// constants and types for the oscillator clock select control block
package osc_ctrl_pkg;

    // register byte addresses and alias offsets
    localparam logic [15:0] OSC_CONTROL_ADDR = 16'hf000;
    localparam logic [15:0] OSC_TUNING_ADDR = 16'hf010;
    localparam logic [15:0] ALIAS_BASE_MASK = 16'hfff0;
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLEAR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INVERT = 2'h3;

    // unlock keys, written in order to the unlock port
    localparam logic [31:0] UNLOCK_KEY_FIRST = 32'haa99_6655;
    localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h5566_99aa;
    localparam logic [15:0] UNLOCK_ADDR = 16'hf0f0;

    // control register field positions
    localparam int POS_PLL_ODIV = 27;
    localparam int POS_FRC_DIV = 24;
    localparam int POS_SOSC_RDY = 22;
    localparam int POS_PB_RDY = 21;
    localparam int POS_PB_DIV = 19;
    localparam int POS_PLL_MULT = 16;
    localparam int POS_CUR_SRC = 12;
    localparam int POS_NEW_SRC = 8;
    localparam int POS_LOCK = 7;
    localparam int POS_USB_LOCK = 6;
    localparam int POS_SYS_LOCK = 5;
    localparam int POS_SLEEP_EN = 4;
    localparam int POS_CLK_FAIL = 3;
    localparam int POS_USB_FRC = 2;
    localparam int POS_SOSC_EN = 1;
    localparam int POS_SWITCH = 0;
    localparam int TUNING_WIDTH = 6;

    // fixed reset values of the fast rc divider and the peripheral clock divisor
    localparam logic [2:0] FRC_DIV_RESET = 3'h1;
    localparam logic [1:0] PB_DIV_DEFAULT = 2'h3;

    // switch settle time in the oscillator domain, in ns
    localparam int SWITCH_SETTLE_NS = 64;
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int SWITCH_SETTLE_CYCLES =
        (SWITCH_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [2:0] {
        SRC_FRC = 3'h0,
        SRC_FRC_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOW_POWER_RC_OSC = 3'h5,
        SRC_FRC_DIV16 = 3'h6,
        SRC_FRC_DIVN = 3'h7
    } source_type;

    // configuration word fields sampled at power-on
    typedef struct packed {
        logic [2:0] startup_source_config;
        logic [1:0] switch_monitor_config;
        logic [2:0] pll_output_divider;
        logic [2:0] pll_multiplier;
        logic [1:0] periph_clock_divisor;
        logic secondary_osc_enable;
    } device_config_words_type;

    // oscillator status coming from the analog side
    typedef struct packed {
        logic secondary_osc_ready;
        logic usb_pll_locked;
        logic sys_pll_locked;
        logic clock_failed;
    } osc_status_type;

    // settings driven out to the clock generators
    typedef struct packed {
        logic [2:0] current_source_sel;
        logic [2:0] pll_output_divider;
        logic [2:0] pll_multiplier;
        logic [2:0] fast_rc_divider;
        logic [1:0] periph_clock_divisor;
        logic usb_fast_rc_select;
        logic secondary_osc_enable;
        logic [5:0] tuning_field;
    } osc_settings_type;

endpackage

// [rtl/osc_clock_select.sv]
// oscillator control and clock source switch logic
`timescale 1ns/1ps
// Summary of operation
// - pll output divider: 1,2,4,8,16,32,64,256
// - fast rc divider same codes, reset 001
// - secondary ready flag reads stable oscillator
// - divisor ready shows divisor is writable
// - peripheral clock divisor 1,2,4,8, default 11
// - pll multiplier 15 to 21, then 24
// - current source reports active clock code
// - new source loads startup config at power-on
// - lock freezes selections when config 1x
// - usb pll lock flag reads lock status
// - system pll lock flag reads lock status
// - sleep enable picks sleep or idle
// - clock fail flag set on detected failure
// - usb clock from fast rc when set
// - secondary oscillator enable bit
// - switch request cleared when switch completes
// - control writes need unlock sequence first
// - clear, set, invert aliases at +4,+8,+c
// - configured fields load at power-on
module osc_clock_select #(
    parameter int SETTLE_CYCLES = osc_ctrl_pkg::SWITCH_SETTLE_CYCLES
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // power-on marker and configuration words
    input wire logic power_on_reset_i,
    input wire osc_ctrl_pkg::device_config_words_type config_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [31:0] rdata_o,
    // oscillator status pins from the analog side
    input wire osc_ctrl_pkg::osc_status_type status_i,
    input wire logic wait_exec_i,
    // outputs to the clock generators and power control
    output osc_ctrl_pkg::osc_settings_type settings_o,
    output logic [8:0] pll_odiv_ratio_o,
    output logic [8:0] frc_div_ratio_o,
    output logic [3:0] pb_div_ratio_o,
    output logic [4:0] pll_mult_ratio_o,
    output logic enter_sleep_o,
    output logic enter_idle_o
);
    typedef enum {
        SW_IDLE,
        SW_SETTLE
    } switch_state_type;

    switch_state_type sw_state;
    osc_ctrl_pkg::osc_status_type status_meta, status_sync;
    logic [2:0] pll_output_divider, fast_rc_divider, pll_multiplier;
    logic [2:0] current_source_sel, new_source_sel;
    logic [1:0] periph_clock_divisor, switch_monitor_config;
    logic clock_select_lock, sleep_on_wait_enable, clock_fail_flag;
    logic usb_fast_rc_select, secondary_osc_enable, switch_request;
    logic [5:0] tuning_field;
    logic [1:0] unlock_step;
    logic unlocked;
    logic [15:0] settle_count;
    logic [31:0] control_word, tuning_word, cur_word, next_word;
    logic hit_control, hit_tuning, ctrl_write, tune_write, selection_frozen;
    logic periph_divisor_ready, switch_done;

    // status pins come from other clocks: two flops before use
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            status_meta <= '0;
            status_sync <= '0;
        end else if (clk_en_i) begin
            status_meta <= status_i;
            status_sync <= status_meta;
        end
    end

    assign hit_control = (addr_i & osc_ctrl_pkg::ALIAS_BASE_MASK) ==
                         osc_ctrl_pkg::OSC_CONTROL_ADDR;
    assign hit_tuning = (addr_i & osc_ctrl_pkg::ALIAS_BASE_MASK) ==
                        osc_ctrl_pkg::OSC_TUNING_ADDR;

    // config 1x with lock set freezes clock and pll selections
    assign selection_frozen = switch_monitor_config[1] &&
                              clock_select_lock;
    // divisor writable only while no switch is in flight
    assign periph_divisor_ready = !switch_request;

    assign control_word = {
        2'h0,
        pll_output_divider,
        fast_rc_divider,
        1'b0,
        status_sync.secondary_osc_ready,
        periph_divisor_ready,
        periph_clock_divisor,
        pll_multiplier,
        1'b0,
        current_source_sel,
        1'b0,
        new_source_sel,
        clock_select_lock,
        status_sync.usb_pll_locked,
        status_sync.sys_pll_locked,
        sleep_on_wait_enable,
        clock_fail_flag,
        usb_fast_rc_select,
        secondary_osc_enable,
        switch_request
    };
    assign tuning_word = {26'h0, tuning_field};

    // alias decode: plain write, clear, set, invert
    always_comb begin
        cur_word = hit_control ? control_word : tuning_word;
        unique case (addr_i[3:2])
            osc_ctrl_pkg::ALIAS_WRITE: next_word = wdata_i;
            osc_ctrl_pkg::ALIAS_CLEAR: next_word = cur_word & ~wdata_i;
            osc_ctrl_pkg::ALIAS_SET: next_word = cur_word | wdata_i;
            osc_ctrl_pkg::ALIAS_INVERT: next_word = cur_word ^ wdata_i;
        endcase
    end

    // control writes need the unlock; one unlock covers one write
    assign ctrl_write = clk_en_i && write_i && hit_control && unlocked;
    assign tune_write = clk_en_i && write_i && hit_tuning;

    // unlock sequence: two keys in order to the unlock address
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            unlock_step <= 2'h0;
            unlocked <= 1'b0;
        end else if (clk_en_i && write_i) begin
            if (addr_i == osc_ctrl_pkg::UNLOCK_ADDR) begin
                if (wdata_i == osc_ctrl_pkg::UNLOCK_KEY_FIRST) begin
                    unlock_step <= 2'h1;
                    unlocked <= 1'b0;
                end else if (unlock_step == 2'h1 &&
                             wdata_i == osc_ctrl_pkg::UNLOCK_KEY_SECOND) begin
                    unlock_step <= 2'h0;
                    unlocked <= 1'b1;
                end else begin
                    unlock_step <= 2'h0;
                    unlocked <= 1'b0;
                end
            end else if (hit_control) begin
                unlocked <= 1'b0;
                unlock_step <= 2'h0;
            end
        end
    end

    // configured fields load from configuration on power-on only
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fast_rc_divider <= osc_ctrl_pkg::FRC_DIV_RESET;
            clock_select_lock <= 1'b0;
            sleep_on_wait_enable <= 1'b0;
            usb_fast_rc_select <= 1'b0;
            pll_output_divider <= '0;
            pll_multiplier <= '0;
            periph_clock_divisor <= osc_ctrl_pkg::PB_DIV_DEFAULT;
            new_source_sel <= '0;
            secondary_osc_enable <= 1'b0;
            switch_monitor_config <= '0;
        end else if (clk_en_i && power_on_reset_i) begin
            pll_output_divider <= config_i.pll_output_divider;
            pll_multiplier <= config_i.pll_multiplier;
            periph_clock_divisor <= config_i.periph_clock_divisor;
            new_source_sel <= config_i.startup_source_config;
            secondary_osc_enable <= config_i.secondary_osc_enable;
            switch_monitor_config <= config_i.switch_monitor_config;
        end else if (ctrl_write) begin
            fast_rc_divider <= next_word[osc_ctrl_pkg::POS_FRC_DIV +: 3];
            clock_select_lock <= next_word[osc_ctrl_pkg::POS_LOCK];
            sleep_on_wait_enable <= next_word[osc_ctrl_pkg::POS_SLEEP_EN];
            usb_fast_rc_select <= next_word[osc_ctrl_pkg::POS_USB_FRC];
            secondary_osc_enable <= next_word[osc_ctrl_pkg::POS_SOSC_EN];
            if (periph_divisor_ready) begin
                periph_clock_divisor <=
                    next_word[osc_ctrl_pkg::POS_PB_DIV +: 2];
            end
            if (!selection_frozen) begin
                pll_output_divider <=
                    next_word[osc_ctrl_pkg::POS_PLL_ODIV +: 3];
                pll_multiplier <= next_word[osc_ctrl_pkg::POS_PLL_MULT +: 3];
                new_source_sel <= next_word[osc_ctrl_pkg::POS_NEW_SRC +: 3];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tuning_field <= '0;
        end else if (tune_write) begin
            tuning_field <= next_word[osc_ctrl_pkg::TUNING_WIDTH-1:0];
        end
    end

    // failure sets the flag; a set beats a software clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clock_fail_flag <= 1'b0;
        end else if (clk_en_i) begin
            if (status_sync.clock_failed) begin
                clock_fail_flag <= 1'b1;
            end else if (ctrl_write) begin
                clock_fail_flag <= next_word[osc_ctrl_pkg::POS_CLK_FAIL];
            end
        end
    end

    // switch request and sequencer; done clears request, moves source
    assign switch_done = (sw_state == SW_SETTLE) &&
                         (settle_count == 16'(SETTLE_CYCLES - 1));

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            switch_request <= 1'b0;
        end else if (clk_en_i) begin
            if (switch_done) begin
                switch_request <= 1'b0;
            end else if (ctrl_write && !selection_frozen &&
                         next_word[osc_ctrl_pkg::POS_SWITCH]) begin
                switch_request <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sw_state <= SW_IDLE;
            settle_count <= '0;
        end else if (clk_en_i) begin
            unique case (sw_state)
                SW_IDLE: begin
                    settle_count <= '0;
                    if (switch_request) begin
                        sw_state <= SW_SETTLE;
                    end
                end
                SW_SETTLE: begin
                    settle_count <= settle_count + 16'h1;
                    if (switch_done) begin
                        sw_state <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // current source follows the startup choice at power-on
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            current_source_sel <= '0;
        end else if (clk_en_i) begin
            if (power_on_reset_i) begin
                current_source_sel <= config_i.startup_source_config;
            end else if (switch_done) begin
                current_source_sel <= new_source_sel;
            end
        end
    end

    // divide and multiply ratios decoded for the clock generators
    always_comb begin
        pll_odiv_ratio_o = (pll_output_divider == 3'h7) ? 9'h100 :
                           9'(9'h1 << pll_output_divider);
        frc_div_ratio_o = (fast_rc_divider == 3'h7) ? 9'h100 :
                          9'(9'h1 << fast_rc_divider);
        pb_div_ratio_o = 4'(4'h1 << periph_clock_divisor);
        pll_mult_ratio_o = (pll_multiplier == 3'h7) ? 5'h18 :
                           5'(5'hf + {2'h0, pll_multiplier});
    end

    assign settings_o = '{
        current_source_sel: current_source_sel,
        pll_output_divider: pll_output_divider,
        pll_multiplier: pll_multiplier,
        fast_rc_divider: fast_rc_divider,
        periph_clock_divisor: periph_clock_divisor,
        usb_fast_rc_select: usb_fast_rc_select,
        secondary_osc_enable: secondary_osc_enable,
        tuning_field: tuning_field
    };

    // wait instruction: sleep when enabled, else idle
    assign enter_sleep_o = wait_exec_i && sleep_on_wait_enable;
    assign enter_idle_o = wait_exec_i && !sleep_on_wait_enable;

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (clk_en_i) begin
            if (read_i && hit_control) begin
                rdata_o <= control_word;
            end else if (read_i && hit_tuning) begin
                rdata_o <= tuning_word;
            end else begin
                rdata_o <= '0;
            end
        end
    end
endmodule // osc_clock_select

// [verif/osc_clock_select_asserts.sv]
// port assertions for the oscillator clock select block
`timescale 1ns/1ps
module osc_clock_select_asserts #(
    parameter int SETTLE_CYCLES = 8
) (
    // clock and control
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic power_on_reset_i,
    input wire osc_ctrl_pkg::device_config_words_type config_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [31:0] rdata_o,
    // status and outputs
    input wire osc_ctrl_pkg::osc_status_type status_i,
    input wire logic wait_exec_i,
    input wire osc_ctrl_pkg::osc_settings_type settings_o,
    input wire logic [8:0] pll_odiv_ratio_o,
    input wire logic [8:0] frc_div_ratio_o,
    input wire logic [3:0] pb_div_ratio_o,
    input wire logic [4:0] pll_mult_ratio_o,
    input wire logic enter_sleep_o,
    input wire logic enter_idle_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_ctl;
    logic [2:0] od, fd, mu;
    logic [1:0] pd;
    assign rd_ctl = clk_en_i && read_i &&
                    addr_i == osc_ctrl_pkg::OSC_CONTROL_ADDR;
    assign od = settings_o.pll_output_divider;
    assign fd = settings_o.fast_rc_divider;
    assign mu = settings_o.pll_multiplier;
    assign pd = settings_o.periph_clock_divisor;
    chk_wait_mode: assert property
        ((enter_sleep_o | enter_idle_o) == wait_exec_i
        && !(enter_sleep_o && enter_idle_o))
        else $error("wait mode outputs wrong");
    chk_odiv_decode: assert property
        (pll_odiv_ratio_o == (od == 3'h7 ? 9'h100 : 9'h1 << od))
        else $error("pll output divider ratio wrong");
    chk_frc_decode: assert property
        (frc_div_ratio_o == (fd == 3'h7 ? 9'h100 : 9'h1 << fd))
        else $error("fast rc divider ratio wrong");
    chk_pb_decode: assert property (pb_div_ratio_o == 4'h1 << pd)
        else $error("peripheral divisor ratio wrong");
    chk_mult_decode: assert property
        (pll_mult_ratio_o == (mu == 3'h7 ? 5'h18 : 5'hf + mu))
        else $error("pll multiplier ratio wrong");
    chk_field_read: assert property (rd_ctl |=>
        rdata_o[29:24] == {$past(od), $past(fd)}
        && rdata_o[20:16] == {$past(pd), $past(mu)})
        else $error("divider fields read back wrong");
    chk_source_read: assert property (rd_ctl |=>
        rdata_o[14:12] == $past(settings_o.current_source_sel))
        else $error("current source read back wrong");
    chk_usb_sosc_read: assert property (rd_ctl |=>
        rdata_o[2:1] == $past({settings_o.usb_fast_rc_select,
        settings_o.secondary_osc_enable}))
        else $error("usb or secondary enable read back wrong");
    // the status pins pass a two-flop synchroniser, so only settled values
    chk_status_read: assert property (rd_ctl && $stable(status_i)
        && status_i == $past(status_i, 2) |=> {rdata_o[22], rdata_o[6:5]}
        == $past({status_i[3], status_i[2], status_i[1]}))
        else $error("status flags read back wrong");
    cover property (rd_ctl);
    cover property (enter_sleep_o);
    cover property ($changed(settings_o.current_source_sel));
endmodule // osc_clock_select_asserts

bind osc_clock_select osc_clock_select_asserts #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_osc_clock_select_asserts (
    .clock_i, .rst_n_i, .clk_en_i, .power_on_reset_i, .config_i, .addr_i,
    .wdata_i, .write_i, .read_i, .rdata_o, .status_i, .wait_exec_i,
    .settings_o, .pll_odiv_ratio_o, .frc_div_ratio_o, .pb_div_ratio_o,
    .pll_mult_ratio_o, .enter_sleep_o, .enter_idle_o
);

// [verif/tb_osc_clock_select.sv]
// self-checking bench for the oscillator clock select block
`timescale 1ns/1ps
module tb_osc_clock_select;
    logic clock_i, rst_n_i, clk_en_i, power_on_reset_i;
    osc_ctrl_pkg::device_config_words_type config_i;
    logic [15:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic write_i, read_i, wait_exec_i, enter_sleep_o, enter_idle_o;
    osc_ctrl_pkg::osc_status_type status_i;
    osc_ctrl_pkg::osc_settings_type settings_o;
    logic [8:0] pll_odiv_ratio_o, frc_div_ratio_o;
    logic [3:0] pb_div_ratio_o;
    logic [4:0] pll_mult_ratio_o;
    int n_mismatch = 0;
    int check_count = 0;
    localparam logic [15:0] CTL = osc_ctrl_pkg::OSC_CONTROL_ADDR;

    osc_clock_select #(.SETTLE_CYCLES(2)) i_osc_clock_select (
        .clock_i, .rst_n_i, .clk_en_i, .power_on_reset_i, .config_i,
        .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .status_i,
        .wait_exec_i, .settings_o, .pll_odiv_ratio_o, .frc_div_ratio_o,
        .pb_div_ratio_o, .pll_mult_ratio_o, .enter_sleep_o, .enter_idle_o
    );

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one idle cycle between strobes keeps each strobe assigned once a step
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic unl_wr(input logic [15:0] a, input logic [31:0] v);
        wr(osc_ctrl_pkg::UNLOCK_ADDR, osc_ctrl_pkg::UNLOCK_KEY_FIRST);
        wr(osc_ctrl_pkg::UNLOCK_ADDR, osc_ctrl_pkg::UNLOCK_KEY_SECOND);
        wr(a, v);
    endtask

    task automatic power_on(input logic [1:0] mon);
        @(posedge clock_i);
        // startup, monitor, odiv, mult, pb divisor, secondary enable
        config_i <= {3'h2, mon, 3'h3, 3'h5, 2'h2, 1'b1};
        power_on_reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        power_on_reset_i <= 1'b0;
        #1;
    endtask

    task automatic test_reset_values();
        rd(CTL);
        chk(d, 32'h1975_2222);
        chk(settings_o.current_source_sel, 3'h2);
        rd(osc_ctrl_pkg::OSC_TUNING_ADDR);
        chk(d, 32'h0);
        rd(16'hf020);
        chk(d, 32'h0);
        $display("test reset values done");
    endtask

    task automatic test_unlock_aliases();
        wr(CTL + 16'h8, 32'h10);
        rd(CTL);
        chk(d[4], 1'b0);
        unl_wr(CTL + 16'h8, 32'h10);
        @(posedge clock_i);
        wait_exec_i <= 1'b1;
        #1 chk(enter_sleep_o, 1'b1);
        unl_wr(CTL + 16'h4, 32'h10);
        chk(enter_idle_o, 1'b1);
        @(posedge clock_i);
        wait_exec_i <= 1'b0;
        wr(osc_ctrl_pkg::OSC_TUNING_ADDR, 32'h15);
        wr(osc_ctrl_pkg::OSC_TUNING_ADDR + 16'hc, 32'h3f);
        chk(settings_o.tuning_field, 6'h2a);
        $display("test unlock and aliases done");
    endtask

    task automatic test_dividers();
        for (int c = 0; c < 8; c++) begin
            unl_wr(CTL, (c << 27) | (c << 24) | ((c & 3) << 19) |
                (c << 16) | 32'h200 | ((c & 3) << 1));
            chk(pll_odiv_ratio_o, c == 7 ? 256 : 1 << c);
            chk(frc_div_ratio_o, c == 7 ? 256 : 1 << c);
            chk(pb_div_ratio_o, 1 << (c & 3));
            chk(pll_mult_ratio_o, c == 7 ? 24 : 15 + c);
            chk(settings_o.secondary_osc_enable, c & 1);
            chk(settings_o.usb_fast_rc_select, (c >> 1) & 1);
        end
        $display("test dividers done");
    endtask

    task automatic test_switch();
        unl_wr(CTL, 32'h0000_0401);
        rd(CTL);
        chk(d[0], 1'b1);
        chk(d[21], 1'b0);
        for (int i = 0; i < 40 && d[0] === 1'b1; i++) rd(CTL);
        if (d[0] !== 1'b0) begin
            n_mismatch++;
            final_report();
        end
        chk(d[14:12], 3'h4);
        chk(settings_o.current_source_sel, 3'h4);
        chk(d[21], 1'b1);
        $display("test switch done");
    endtask

    task automatic test_clock_fail();
        @(posedge clock_i);
        status_i.clock_failed <= 1'b1;
        repeat (4) @(posedge clock_i);
        status_i.clock_failed <= 1'b0;
        rd(CTL);
        chk(d[3], 1'b1);
        unl_wr(CTL + 16'h4, 32'h8);
        rd(CTL);
        chk(d[3], 1'b0);
        $display("test clock fail done");
    endtask

    task automatic test_lock();
        unl_wr(CTL + 16'h8, 32'h80);
        unl_wr(CTL + 16'h8, 32'h0800_0000);
        chk(pll_odiv_ratio_o, 9'h2);
        power_on(2'h2);
        chk(settings_o.current_source_sel, 3'h2);
        unl_wr(CTL + 16'h8, 32'h80);
        unl_wr(CTL + 16'h4, 32'h1800_0000);
        chk(pll_odiv_ratio_o, 9'h8);
        unl_wr(CTL + 16'h8, 32'h0100_0000);
        chk(frc_div_ratio_o, 9'h2);
        $display("test lock done");
    endtask

    // second reset with flipped status levels, then a write with the clock enable low
    task automatic test_mid_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        // secondary not ready, usb pll locked, system pll unlocked
        status_i <= 4'b0100;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // status needs two enabled edges through the synchroniser
        repeat (3) @(posedge clock_i);
        rd(CTL);
        chk(d, 32'h0138_0040);
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        wr(osc_ctrl_pkg::OSC_TUNING_ADDR, 32'h3f);
        chk(settings_o.tuning_field, 6'h0);
        @(posedge clock_i);
        clk_en_i <= 1'b1;
        wr(osc_ctrl_pkg::OSC_TUNING_ADDR, 32'h3f);
        chk(settings_o.tuning_field, 6'h3f);
        $display("test mid-run reset done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        power_on_reset_i = 1'b0;
        config_i = '0;
        addr_i = 16'h0;
        wdata_i = 32'h0;
        write_i = 1'b0;
        read_i = 1'b0;
        wait_exec_i = 1'b0;
        // ready, usb pll unlocked, system pll locked, no failure
        status_i = 4'b1010;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        power_on(2'h0);
        repeat (4) @(posedge clock_i);
        test_reset_values();
        test_unlock_aliases();
        test_dividers();
        test_switch();
        test_clock_fail();
        test_lock();
        test_mid_reset();
        final_report();
    end

    initial begin
        #800000;
        n_mismatch++;
        final_report();
    end
endmodule // tb_osc_clock_select
